// [rtl/lcsd_defs.vh]
`ifndef LCSD_DEFS_VH
`define LCSD_DEFS_VH
`define LCSD_NBANK        8
`define LCSD_APB_DEV_ST   12'h000
`define LCSD_APB_BANK_ST  12'h004
`define LCSD_APB_LAST     12'h008
`define LCSD_APB_CTRL     12'h00c
`define LCSD_APB_MRW      12'h010
`define LCSD_CTRL_RST     32'h0000_0000
// device state codes as read back
`define LCSD_D_PWRON      4'h0
`define LCSD_D_RESETTING  4'h1
`define LCSD_D_IDLE       4'h2
`define LCSD_D_ACTIVE     4'h3
`define LCSD_D_MRW        4'h4
`define LCSD_D_MRR_IDLE   4'h5
`define LCSD_D_MRR_ACT    4'h6
`define LCSD_D_MRR_RST    4'h7
`define LCSD_D_PD_ACT     4'h8
`define LCSD_D_PD_IDLE    4'h9
`define LCSD_D_PD_RST     4'ha
`define LCSD_D_SREF       4'hb
`define LCSD_D_DPD        4'hc
`define LCSD_D_REF        4'hd
// bank state codes
`define LCSD_B_IDLE       3'h0
`define LCSD_B_ACTIVE     3'h1
`define LCSD_B_READ       3'h2
`define LCSD_B_WRITE      3'h3
`define LCSD_B_PRE        3'h4
`define LCSD_B_REF        3'h5
// mode register address that means reset
`define LCSD_MA_RESET     8'h3f
`endif

// [rtl/lcsd_mr_mem.v]
`timescale 1ns/10ps
`default_nettype none
// small mode register store, registered read port
module lcsd_mr_mem
(
  input  wire       clk,
  input  wire       we,
  input  wire [7:0] waddr,
  input  wire [7:0] wdata,
  input  wire [7:0] raddr,
  output reg  [7:0] rdata
);
  reg [7:0] mem_r [0:255];

  // no reset on the array; contents are undefined until written
  always @(posedge clk)
  begin
    if (we)
      mem_r[waddr] <= wdata;
    rdata <= mem_r[raddr];
  end
endmodule
`default_nettype wire

// [rtl/lcsd_top.v]
// Added by the designer: the APB register port and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none
`include "lcsd_defs.vh"
module lcsd_top
(
  input  wire        pclk,
  input  wire        presetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output wire        pready,
  output wire        pslverr,
  input  wire        ck,
  input  wire        cke,
  input  wire        cs_n,
  input  wire [9:0]  ca,
  output reg  [3:0]  dev_state,
  output reg         cmd_valid,
  output reg  [3:0]  cmd_code,
  output reg  [2:0]  cmd_bank,
  output reg  [11:0] cmd_col,
  output reg         cmd_ap
);
  // command codes for the decoded-command output
  localparam [3:0] C_NOP = 4'h0, C_MRW = 4'h1, C_MRR = 4'h2,
                   C_REFPB = 4'h3, C_REFAB = 4'h4, C_ACT = 4'h5,
                   C_WR = 4'h6, C_RD = 4'h7, C_PRE = 4'h8,
                   C_BST = 4'h9, C_SREF = 4'ha, C_DPD = 4'hb,
                   C_PDE = 4'hc, C_EXIT = 4'hd, C_RESET = 4'he;
  // one-hot device states
  localparam [13:0] S_PWRON = 14'h0001, S_RESETTING = 14'h0002,
                    S_IDLE = 14'h0004, S_ACTIVE = 14'h0008,
                    S_MRW = 14'h0010, S_MRRI = 14'h0020,
                    S_MRRA = 14'h0040, S_MRRR = 14'h0080,
                    S_PDA = 14'h0100, S_PDI = 14'h0200,
                    S_PDR = 14'h0400, S_SREF = 14'h0800,
                    S_DPD = 14'h1000, S_REF = 14'h2000;

  // link pins pass two flops into the pclk domain
  reg [1:0] ck_s_r;
  reg [1:0] cke_s_r;
  reg [1:0] csn_s_r;
  reg [9:0] ca_s0_r;
  reg [9:0] ca_s1_r;
  reg       ck_d_r;
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ck_s_r  <= 2'b00;
      cke_s_r <= 2'b11;
      csn_s_r <= 2'b11;
      ca_s0_r <= 10'h000;
      ca_s1_r <= 10'h000;
      ck_d_r  <= 1'b0;
    end
    else
    begin
      ck_s_r  <= {ck_s_r[0], ck};
      cke_s_r <= {cke_s_r[0], cke};
      csn_s_r <= {csn_s_r[0], cs_n};
      ca_s0_r <= ca;
      ca_s1_r <= ca_s0_r;
      ck_d_r  <= ck_s_r[1];
    end
  end
  wire ck_rise = ck_s_r[1] & ~ck_d_r;
  wire ck_fall = ~ck_s_r[1] & ck_d_r;

  // capture both halves; rise half waits for its fall partner
  reg [9:0] ca_r_r;
  reg       csn_r_r;
  reg       cke_n_r;
  reg       cke_p_r;
  reg       half_r;
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ca_r_r  <= 10'h000;
      csn_r_r <= 1'b1;
      cke_n_r <= 1'b1;    // cke parks high; a low start decodes a false exit
      cke_p_r <= 1'b1;
      half_r  <= 1'b0;
    end
    else if (ck_rise)
    begin
      ca_r_r  <= ca_s1_r;
      csn_r_r <= csn_s_r[1];
      cke_p_r <= cke_n_r;
      cke_n_r <= cke_s_r[1];
      half_r  <= 1'b1;
    end
    else if (ck_fall)
      half_r <= 1'b0;
  end
  wire       cmd_go = ck_fall & half_r;
  wire [9:0] ca_f = ca_s1_r;
  // a nop in either encoding
  wire nop_enc = csn_r_r | (ca_r_r[0] & ca_r_r[1] & ca_r_r[2]);

  // decode from cs_n, ca0..ca3 and cke only
  function [3:0] dec_cmd;
    input       csn;
    input [3:0] c;
    input       ckep;
    input       ckec;
    begin
      if (!ckep && ckec)
        dec_cmd = C_EXIT;
      else if (!ckep)
        dec_cmd = C_NOP;
      else if (!ckec)
        dec_cmd = csn ? C_PDE : (c[2:0] == 3'b100) ? C_SREF :
                  (c[2:0] == 3'b011) ? C_DPD : C_NOP;
      else if (csn || c[2:0] == 3'b111)
        dec_cmd = C_NOP;
      else if (c == 4'b0000)
        dec_cmd = C_MRW;
      else if (c == 4'b1000)
        dec_cmd = C_MRR;
      else if (c == 4'b0100)
        dec_cmd = C_REFPB;
      else if (c == 4'b1100)
        dec_cmd = C_REFAB;
      else if (c[1:0] == 2'b10)
        dec_cmd = C_ACT;
      else if (c[2:0] == 3'b001)
        dec_cmd = C_WR;
      else if (c[2:0] == 3'b101)
        dec_cmd = C_RD;
      else if (c == 4'b1011)
        dec_cmd = C_PRE;
      else
        dec_cmd = C_BST;
    end
  endfunction

  wire [3:0] cmd_raw = dec_cmd(nop_enc, ca_r_r[3:0], cke_p_r, cke_n_r);
  wire [7:0] ma = {ca_f[1:0], ca_r_r[9:4]};
  wire [7:0] op = ca_f[9:2];
  wire [3:0] cmd = (cmd_raw == C_MRW && ma == `LCSD_MA_RESET) ? C_RESET
                   : cmd_raw;
  wire [2:0] bank = ca_r_r[9:7];
  wire [11:0] col = {ca_f[9:1], ca_r_r[6:5], 1'b0};
  wire ap = ca_f[0];
  wire ab = ca_r_r[4];

  // apb control: bit0 init interval expired, bit1 state timer done
  reg [31:0] ctrl_r;
  wire init_done = ctrl_r[0];
  wire tmr_done  = ctrl_r[1];

  // bank state array and most recent burst pointer
  reg [2:0]  bst_r [0:`LCSD_NBANK-1];
  reg [7:0]  bap_r;
  reg [2:0]  last_bank_r;
  reg [13:0] st_r;
  reg [13:0] st_nxt;
  integer i;
  integer j;
  integer k;

  // true when every bank is idle
  reg all_idle;
  reg any_act;
  always @*
  begin
    all_idle = 1'b1;
    any_act  = 1'b0;
    for (j = 0; j < `LCSD_NBANK; j = j + 1)
    begin
      if (bst_r[j] != `LCSD_B_IDLE)
        all_idle = 1'b0;
      if (bst_r[j] != `LCSD_B_IDLE && bst_r[j] != `LCSD_B_PRE)
        any_act = 1'b1;
    end
  end

  // device level state machine
  always @*
  begin
    st_nxt = st_r;
    case (st_r)
      S_PWRON:
        if (cmd_go && cmd == C_RESET)
          st_nxt = S_RESETTING;
      S_RESETTING:
        if (cmd_go && cmd == C_MRR)
          st_nxt = S_MRRR;
        else if (cmd_go && cmd == C_PDE)
          st_nxt = S_PDR;
        else if (init_done)
          st_nxt = S_IDLE;
      S_IDLE, S_ACTIVE:
        if (cmd_go)
        begin
          if (cmd == C_RESET && st_r == S_IDLE && all_idle)
            st_nxt = S_RESETTING;
          else if (cmd == C_MRW && all_idle)
            st_nxt = S_MRW;
          else if (cmd == C_MRR)
            st_nxt = any_act ? S_MRRA : S_MRRI;
          else if (cmd == C_REFAB && all_idle)
            st_nxt = S_REF;
          else if (cmd == C_PDE)
            st_nxt = any_act ? S_PDA : S_PDI;
          else if (cmd == C_SREF && all_idle)
            st_nxt = S_SREF;
          else if (cmd == C_DPD && all_idle)
            st_nxt = S_DPD;
        end
      S_MRW, S_MRRI, S_MRRR, S_REF:
        if (tmr_done)
          st_nxt = S_IDLE;
      S_MRRA:
        if (tmr_done)
          st_nxt = S_ACTIVE;
      S_PDA:
        if (cmd_go && cmd == C_EXIT)
          st_nxt = S_ACTIVE;
      S_PDI:
        if (cmd_go && cmd == C_EXIT)
          st_nxt = S_IDLE;
      S_PDR:
        if (cmd_go && cmd == C_EXIT)
          st_nxt = init_done ? S_IDLE : S_RESETTING;
      S_SREF:
        if (cke_s_r[1])
          st_nxt = S_IDLE;
      S_DPD:
        if (cke_s_r[1])
          st_nxt = S_PWRON;
      default:
        st_nxt = S_PWRON;
    endcase
    if (st_nxt == S_IDLE && any_act)
      st_nxt = S_ACTIVE;
    if (st_nxt == S_ACTIVE && !any_act)
      st_nxt = S_IDLE;
  end

  wire bank_cmd = cmd_go && (st_r == S_IDLE || st_r == S_ACTIVE);
  wire mr_we = cmd_go && st_r == S_IDLE && cmd == C_MRW && all_idle;

  // per-bank transitions; timer completion closes transient states
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      for (i = 0; i < `LCSD_NBANK; i = i + 1)
        bst_r[i] <= `LCSD_B_IDLE;
      bap_r       <= 8'h00;
      last_bank_r <= 3'h0;
      st_r        <= S_PWRON;
    end
    else
    begin
      st_r <= st_nxt;
      if (st_nxt == S_PWRON || st_nxt == S_RESETTING)
        for (i = 0; i < `LCSD_NBANK; i = i + 1)
          bst_r[i] <= `LCSD_B_IDLE;
      else if (bank_cmd)
      begin
        case (cmd)
          C_ACT:
            if (bst_r[bank] == `LCSD_B_IDLE)
              bst_r[bank] <= `LCSD_B_ACTIVE;
          C_REFPB:
            if (`LCSD_NBANK == 8 && bst_r[bank] == `LCSD_B_IDLE)
              bst_r[bank] <= `LCSD_B_REF;
          C_RD, C_WR:
            if (bst_r[bank] == `LCSD_B_ACTIVE ||
                bst_r[bank] == `LCSD_B_READ ||
                bst_r[bank] == `LCSD_B_WRITE)
            begin
              bst_r[bank] <= (cmd == C_RD) ? `LCSD_B_READ
                                           : `LCSD_B_WRITE;
              bap_r[bank] <= ap;
              last_bank_r <= bank;
            end
          C_BST:
            if (bst_r[last_bank_r] == `LCSD_B_READ ||
                bst_r[last_bank_r] == `LCSD_B_WRITE)
              bst_r[last_bank_r] <= bap_r[last_bank_r] ? `LCSD_B_PRE
                                  : `LCSD_B_ACTIVE;
          C_PRE:
            for (i = 0; i < `LCSD_NBANK; i = i + 1)
              if ((ab || i == bank) &&
                  (bst_r[i] == `LCSD_B_IDLE ||
                   bst_r[i] == `LCSD_B_ACTIVE))
                bst_r[i] <= `LCSD_B_PRE;
          default:
            bst_r[0] <= bst_r[0];
        endcase
      end
      else if (tmr_done)
        for (i = 0; i < `LCSD_NBANK; i = i + 1)
          if (bst_r[i] == `LCSD_B_PRE || bst_r[i] == `LCSD_B_REF)
            bst_r[i] <= `LCSD_B_IDLE;
          else if (bap_r[i] && (bst_r[i] == `LCSD_B_READ ||
                                bst_r[i] == `LCSD_B_WRITE))
            bst_r[i] <= `LCSD_B_PRE;
    end
  end

  // mode register store
  wire [7:0] mr_rdata;
  lcsd_mr_mem u_mr
  (
    .clk   (pclk),
    .we    (mr_we),
    .waddr (ma),
    .wdata (op),
    .raddr (pwdata[7:0]),
    .rdata (mr_rdata)
  );

  // state code for readback
  function [3:0] st_code;
    input [13:0] s;
    begin
      case (s)
        S_RESETTING: st_code = `LCSD_D_RESETTING;
        S_IDLE:      st_code = `LCSD_D_IDLE;
        S_ACTIVE:    st_code = `LCSD_D_ACTIVE;
        S_MRW:       st_code = `LCSD_D_MRW;
        S_MRRI:      st_code = `LCSD_D_MRR_IDLE;
        S_MRRA:      st_code = `LCSD_D_MRR_ACT;
        S_MRRR:      st_code = `LCSD_D_MRR_RST;
        S_PDA:       st_code = `LCSD_D_PD_ACT;
        S_PDI:       st_code = `LCSD_D_PD_IDLE;
        S_PDR:       st_code = `LCSD_D_PD_RST;
        S_SREF:      st_code = `LCSD_D_SREF;
        S_DPD:       st_code = `LCSD_D_DPD;
        S_REF:       st_code = `LCSD_D_REF;
        default:     st_code = `LCSD_D_PWRON;
      endcase
    end
  endfunction

  // registered status outputs and last command record
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      dev_state <= `LCSD_D_PWRON;
      cmd_valid <= 1'b0;
      cmd_code  <= C_NOP;
      cmd_bank  <= 3'h0;
      cmd_col   <= 12'h000;
      cmd_ap    <= 1'b0;
    end
    else
    begin
      dev_state <= st_code(st_nxt);
      cmd_valid <= cmd_go && cmd != C_NOP;
      if (cmd_go && cmd != C_NOP)
      begin
        cmd_code <= cmd;
        cmd_bank <= bank;
        cmd_col  <= col;
        cmd_ap   <= ap;
      end
    end
  end

  // apb slave: zero wait states, unmapped reads zero with error
  wire acc = psel & penable;
  wire hit = (paddr == `LCSD_APB_DEV_ST) || (paddr == `LCSD_APB_BANK_ST) ||
             (paddr == `LCSD_APB_LAST) || (paddr == `LCSD_APB_CTRL) ||
             (paddr == `LCSD_APB_MRW);
  assign pready  = 1'b1;
  assign pslverr = acc & ~hit;
  reg [23:0] bank_flat;
  always @*
  begin
    bank_flat = 24'h000000;
    for (k = 0; k < `LCSD_NBANK; k = k + 1)
      bank_flat[k*3 +: 3] = bst_r[k];
  end
  // timer-done bit is a one-shot so transient states close exactly once
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      ctrl_r <= `LCSD_CTRL_RST;
    else if (acc && pwrite && paddr == `LCSD_APB_CTRL)
      ctrl_r <= pwdata;
    else
      ctrl_r[1] <= 1'b0;
  end
  always @*
  begin
    if (paddr == `LCSD_APB_DEV_ST)
      prdata = {28'h0000000, dev_state};
    else if (paddr == `LCSD_APB_BANK_ST)
      prdata = {8'h00, bank_flat};
    else if (paddr == `LCSD_APB_LAST)
      prdata = {12'h000, cmd_ap, cmd_bank, cmd_col, cmd_code};
    else if (paddr == `LCSD_APB_CTRL)
      prdata = ctrl_r;
    else if (paddr == `LCSD_APB_MRW)
      prdata = {24'h000000, mr_rdata};
    else
      prdata = 32'h00000000;
  end
endmodule
`default_nettype wire

// [testbench/lcsd_ctl_model.sv]
`timescale 1ns/10ps
`default_nettype none
// controller side: ck runs only inside a command frame
module lcsd_ctl_model
(
  input  wire logic  pclk,
  output logic       ck,
  output logic       cke,
  output logic       cs_n,
  output logic [9:0] ca
);
  // parked link: clock low, deselected, cke high
  initial
  begin
    ck = 1'b0;
    cke = 1'b1;
    cs_n = 1'b1;
    ca = 10'h000;
  end
  // one ck cycle in a 25 pclk frame, 8 pclk high, rise half then fall half
  task automatic frame(input logic k, input logic s, input logic [9:0] r,
                       input logic [9:0] f);
    @(posedge pclk);
    cke <= k;
    cs_n <= s;
    ca <= r;
    repeat (8) @(posedge pclk);
    ck <= 1'b1;
    repeat (4) @(posedge pclk);
    ca <= f;
    repeat (4) @(posedge pclk);
    ck <= 1'b0;
    repeat (8) @(posedge pclk);
    cs_n <= 1'b1;
    ca <= ~f; // parked ca flips, always a valid level
  endtask
  // wake from self refresh or deep power-down with ck held still
  task automatic wake;
    @(posedge pclk);
    cke <= 1'b1;
    repeat (10) @(posedge pclk);
  endtask
endmodule
`default_nettype wire

// [testbench/lcsd_top_monitor.sv]
`timescale 1ns/10ps
`default_nettype none
`include "lcsd_defs.vh"
// watches decoded commands and device state moves at the top ports
module lcsd_top_monitor
(
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic [3:0]  dev_state,
  input wire logic        cmd_valid,
  input wire logic [3:0]  cmd_code,
  input wire logic [11:0] cmd_col
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  AST_COL0: assert property (cmd_valid |-> !cmd_col[0])
    else $error("column bit zero not clear");
  AST_NOP_QUIET: assert property (cmd_valid |-> cmd_code != 4'h0)
    else $error("nop flagged as command");
  AST_ONE_PULSE: assert property (cmd_valid |=> !cmd_valid)
    else $error("command pulse longer than one cycle");
  AST_RESET_CMD: assert property (cmd_valid && cmd_code == 4'he
    |-> ##[0:4] dev_state == `LCSD_D_RESETTING)
    else $error("reset command did not start init");
  AST_MRW_ENTRY: assert property (cmd_valid && cmd_code == 4'h1
    |-> ##[0:4] dev_state == `LCSD_D_MRW)
    else $error("mode write state not entered");
  AST_MRR_ENTRY: assert property (cmd_valid && cmd_code == 4'h2
    |-> ##[0:4] dev_state inside {`LCSD_D_MRR_IDLE, `LCSD_D_MRR_ACT,
                                  `LCSD_D_MRR_RST})
    else $error("mode read state not entered");
  AST_ACT_ENTRY: assert property (cmd_valid && cmd_code == 4'h5
    |-> ##[0:4] dev_state == `LCSD_D_ACTIVE)
    else $error("activate did not reach active");
  AST_SREF_EXIT: assert property ($past(dev_state) == `LCSD_D_SREF
    && dev_state != `LCSD_D_SREF |-> dev_state == `LCSD_D_IDLE)
    else $error("self refresh exit not to idle");
  AST_DPD_EXIT: assert property ($past(dev_state) == `LCSD_D_DPD
    && dev_state != `LCSD_D_DPD |-> dev_state == `LCSD_D_PWRON)
    else $error("deep power-down exit not to power-on");
  AST_PDR_EXIT: assert property ($past(dev_state) == `LCSD_D_PD_RST
    && dev_state != `LCSD_D_PD_RST
    |-> dev_state inside {`LCSD_D_IDLE, `LCSD_D_RESETTING})
    else $error("resetting power-down exit wrong");
  AST_PDA_ENTRY: assert property ($changed(dev_state)
    && dev_state == `LCSD_D_PD_ACT |-> $past(dev_state) == `LCSD_D_ACTIVE)
    else $error("active power-down from wrong state");
endmodule
`default_nettype wire

// [testbench/lcsd_top_tb.sv]
`timescale 1ns/10ps
`default_nettype none
`include "lcsd_defs.vh"
module lcsd_top_tb;
  logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
  logic        pwrite = 1'b0, pready, pslverr, ck, cke, cs_n, cmd_valid;
  logic        cmd_ap, slv, ini = 1'b0;
  logic [11:0] paddr = 12'h000, cmd_col, cl;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [9:0]  ca;
  logic [3:0]  dev_state, cmd_code;
  logic [2:0]  cmd_bank;
  logic [7:0]  op;
  int          error_cnt = 0, compares = 0, last_b = 0, last_ap = 0;
  int          bk[8];

  lcsd_top dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .ck(ck),
    .cke(cke), .cs_n(cs_n), .ca(ca), .dev_state(dev_state),
    .cmd_valid(cmd_valid), .cmd_code(cmd_code), .cmd_bank(cmd_bank),
    .cmd_col(cmd_col), .cmd_ap(cmd_ap));
  lcsd_ctl_model ctl_u (.pclk(pclk), .ck(ck), .cke(cke), .cs_n(cs_n),
    .ca(ca));

  // 200 mhz register clock
  always #2.5 pclk = ~pclk;

  task automatic finish_test;
    if (error_cnt == 0 && compares > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("wrong value at %0t: got %h exp %h", $time, got, exp);
    end
  endtask

  // apb master: request held until pready is seen at an edge
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1 && n < 50)
    begin
      @(posedge pclk);
      n++;
    end
    if (n == 50)
      error_cnt++;
    rd = prdata;
    slv = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // state moves take a few cycles through the link synchroniser
  task automatic wait_dev(input logic [3:0] e);
    int n;
    n = 0;
    while (dev_state !== e && n < 40)
    begin
      @(posedge pclk);
      n++;
    end
    cmp(dev_state, e);
  endtask

  task automatic chk_banks;
    logic [31:0] e;
    e = 32'h0;
    for (int i = 0; i < `LCSD_NBANK; i++)
      e[3*i +: 3] = bk[i][2:0];
    apb(1'b0, `LCSD_APB_BANK_ST, 32'h0);
    cmp(rd, e);
  endtask

  // timer pulse ends timed states; only nop is sent meanwhile
  task automatic tick;
    apb(1'b1, `LCSD_APB_CTRL, {30'h0, 1'b1, ini});
    foreach (bk[i])
      if (bk[i] > 3)
        bk[i] = 0;
  endtask

  // one frame, bounded wait for the decode pulse, fields, model step
  task automatic cmd(input logic k, input logic s, input logic [9:0] r,
                     input logic [9:0] f, input logic [3:0] c);
    int n;
    n = 0;
    fork
      ctl_u.frame(k, s, r, f);
      // looked at mid-cycle, where the one-cycle pulse has settled
      while (cmd_valid !== 1'b1 && n < 60)
      begin
        @(negedge pclk);
        n++;
      end
    join
    cmp(n < 60, c != 4'h0);
    if (c != 4'h0)
      cmp(cmd_code, c);
    if (c inside {4'h5, 4'h6, 4'h7, 4'h8})
      cmp(cmd_bank, r[9:7]);
    if (c inside {4'h6, 4'h7})
    begin
      cmp(cmd_col, {f[9:1], r[6:5], 1'b0});
      cmp(cmd_ap, f[0]);
      last_b = r[9:7];
      last_ap = f[0];
      bk[r[9:7]] = (c == 4'h7) ? 2 : 3;
    end
    if (c == 4'h5)
      bk[r[9:7]] = 1;
    if (c == 4'h3)
      bk[r[9:7]] = 5;
    if (c == 4'h9)
      bk[last_b] = last_ap ? 4 : 1;
    if (c == 4'h8)
      foreach (bk[i])
        if (r[4] ? bk[i] < 2 : i == r[9:7])
          bk[i] = 4;
  endtask

  task automatic nop2;
    repeat (2) cmd(1'b1, 1'b1, 10'h3ff, 10'h3ff, 4'h0);
  endtask

  // burst at a random column
  task automatic rw(input logic [2:0] b, input logic w, input logic ap);
    cl = 12'($urandom);
    cmd(1'b1, 1'b0, {b, cl[2:1], 2'b00, !w, 2'b01}, {cl[11:3], ap},
        w ? 4'h6 : 4'h7);
    if (!ap)
      chk_banks();
  endtask

  initial
  begin
    bk = '{default: 0};
    void'($urandom(8813));
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    wait_dev(`LCSD_D_PWRON);
    apb(1'b0, `LCSD_APB_CTRL, 32'h0);
    cmp(rd, `LCSD_CTRL_RST);
    apb(1'b0, 12'h0fc, 32'h0);
    cmp(slv, 1'b1);
    cmp(rd, 32'h0);
    cmd(1'b1, 1'b0, 10'h3f0, 10'h000, 4'he);
    wait_dev(`LCSD_D_RESETTING);
    cmd(1'b0, 1'b1, 10'h3ff, 10'h3ff, 4'hc);
    wait_dev(`LCSD_D_PD_RST);
    cmd(1'b1, 1'b1, 10'h155, 10'h2aa, 4'hd);
    wait_dev(`LCSD_D_RESETTING);
    nop2();
    cmd(1'b1, 1'b0, 10'h007, 10'h000, 4'h0);
    cmd(1'b1, 1'b0, 10'h008, 10'h000, 4'h2);
    wait_dev(`LCSD_D_MRR_RST);
    ini = 1'b1;
    tick();
    wait_dev(`LCSD_D_IDLE);
    op = 8'($urandom);
    cmd(1'b1, 1'b0, 10'h050, {op, 2'b00}, 4'h1);
    wait_dev(`LCSD_D_MRW);
    tick();
    wait_dev(`LCSD_D_IDLE);
    apb(1'b1, `LCSD_APB_MRW, 32'h5);
    apb(1'b0, `LCSD_APB_MRW, 32'h5);
    cmp(rd, {24'h0, op});
    cmd(1'b1, 1'b0, 10'h058, 10'h000, 4'h2);
    wait_dev(`LCSD_D_MRR_IDLE);
    tick();
    wait_dev(`LCSD_D_IDLE);
    cmd(1'b1, 1'b0, 10'h00c, 10'h000, 4'h4);
    wait_dev(`LCSD_D_REF);
    tick();
    cmd(1'b1, 1'b0, 10'h004, 10'h000, 4'h3);
    chk_banks();
    tick();
    wait_dev(`LCSD_D_IDLE);
    cmd(1'b0, 1'b0, 10'h004, 10'h000, 4'ha);
    wait_dev(`LCSD_D_SREF);
    ctl_u.wake();
    wait_dev(`LCSD_D_IDLE);
    // first clocked edge after an async wake still records the cke rise
    cmd(1'b1, 1'b1, 10'h3ff, 10'h3ff, 4'hd);
    nop2();
    cmd(1'b0, 1'b1, 10'h2aa, 10'h155, 4'hc);
    wait_dev(`LCSD_D_PD_IDLE);
    cmd(1'b1, 1'b1, 10'h155, 10'h2aa, 4'hd);
    wait_dev(`LCSD_D_IDLE);
    nop2();
    for (int b = 0; b < `LCSD_NBANK; b++)
    begin
      cmd(1'b1, 1'b0, {b[2:0], 7'h02}, 10'($urandom), 4'h5);
      wait_dev(`LCSD_D_ACTIVE);
      chk_banks();
      rw(b[2:0], 1'b0, 1'b0);
      rw(b[2:0], 1'b0, 1'b0);
      rw(b[2:0], 1'b1, 1'b0);
      rw(b[2:0], 1'b1, 1'b0);
      rw(b[2:0], b[0], 1'b0);
      cmd(1'b1, 1'b0, 10'h003, 10'h000, 4'h9);
      chk_banks();
    end
    cmd(1'b0, 1'b1, 10'h000, 10'h000, 4'hc);
    wait_dev(`LCSD_D_PD_ACT);
    cmd(1'b1, 1'b1, 10'h000, 10'h000, 4'hd);
    wait_dev(`LCSD_D_ACTIVE);
    nop2();
    rw(3'h1, 1'b0, 1'b0);
    rw(3'h4, 1'b1, 1'b0);
    cmd(1'b1, 1'b0, 10'h003, 10'h000, 4'h9);
    chk_banks();
    rw(3'h1, 1'b0, 1'b1);
    cmd(1'b1, 1'b0, 10'h003, 10'h000, 4'h9);
    chk_banks();
    tick();
    chk_banks();
    cmd(1'b1, 1'b0, 10'h10b, 10'h000, 4'h8);
    chk_banks();
    cmd(1'b1, 1'b0, 10'h01b, 10'h000, 4'h8);
    chk_banks();
    tick();
    wait_dev(`LCSD_D_IDLE);
    chk_banks();
    cmd(1'b0, 1'b0, 10'h003, 10'h000, 4'hb);
    wait_dev(`LCSD_D_DPD);
    ctl_u.wake();
    wait_dev(`LCSD_D_PWRON);
    finish_test();
  end

  // hang guard, far beyond the expected run
  initial
  begin
    #400000;
    error_cnt++;
    finish_test();
  end
endmodule

bind lcsd_top lcsd_top_monitor mon_u (.pclk(pclk), .presetn(presetn),
  .dev_state(dev_state), .cmd_valid(cmd_valid), .cmd_code(cmd_code),
  .cmd_col(cmd_col));
`default_nettype wire
